// ==== design/czd_string_drawer.sv ====
// Character string drawer: APB registers, string sequencer and pen position
`timescale 1ns/100ps
// Operation
// - Width and skip codes scale by two when cell scale is 0, four when 1.
// - Return select 0 stores only the X part of the return operand.
// - Font base coordinates are the 8-bit components times 16.
// - Single plane font reads the selected plane and replicates to active planes.
// - Invert bit 0 applies pattern as read; 1 inverts it first.
// - Graphical set writes colour under pattern ones, leaves zeros untouched.
// - Inverted graphical set paints colour where the font bit is zero.
// - The start bit loads the pen from the begin operand before the first character; the current bit keeps the pen.
// - Attribute word sits at font base X, font base Y plus code.
// - A nonzero width code marks a printing character that is copied.
// - Direction 00 places the cell below and right of the pen.
// - Scaled skip scan lines are passed over without destination writes.
// - Copy only the words the scaled width needs; drop unused right bits.
// - Only active planes are written; inactive planes stay untouched.
// - Font source plane is read even when its activity bit is clear.
// - Left to right characters advance pen X by the inter-character offset.
// - A set continuation bit fetches the next code from the character FIFO.
// - Two fonts of up to 4096 entries, chosen per list entry.
// - A pattern word straddling a word boundary takes two memory writes.
// - Clear continuation, or nonprinting end-of-string, ends the string.
// - Nonprinting return code: 00 none, 01 X, 10 Y, 11 both from return.
// - Direction 10 adds the offset to pen Y, 11 subtracts it.
module czd_string_drawer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chr_valid,
    input wire logic [13:0] chr_entry,
    output logic chr_ready,
    output logic mem_req,
    output logic mem_we,
    output logic [7:0] mem_xw,
    output logic [11:0] mem_y,
    output logic [63:0] mem_wdata,
    output logic [63:0] mem_wmask,
    input wire logic [63:0] mem_rdata,
    input wire logic mem_ack,
    output logic busy
);
    import czd_pkg::*;

    function automatic logic [5:0] scaled(input logic [3:0] code, input logic cs);
        scaled = cs ? {code, 2'b00} : {1'b0, code, 1'b0};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADDR_FONT_CFG) || (a == ADDR_FONT_BASE) || (a == ADDR_RETURN)
            || (a == ADDR_STR_CFG) || (a == ADDR_BEGIN) || (a == ADDR_CMD)
            || (a == ADDR_PEN);
    endfunction

    czd_state_type state_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [1:0] fp_q;
    logic cs_q;
    logic rc_q;
    logic [31:0] fbase_q;
    logic [11:0] ret_q;
    logic sp_q;
    logic si_q;
    logic [2:0] op_q;
    logic [3:0] active_q;
    logic [3:0] colour_q;
    logic [5:0] cell_h_q;
    logic [11:0] begin_x_q;
    logic [11:0] begin_y_q;
    logic [11:0] pen_x_q;
    logic [11:0] pen_y_q;
    logic busy_q;
    logic chr_ready_q;
    logic mem_req_q;
    logic mem_we_q;
    logic [7:0] mem_xw_q;
    logic [11:0] mem_y_q;
    logic [63:0] mem_wdata_q;
    logic [63:0] mem_wmask_q;
    logic [11:0] code_q;
    logic fsel_q;
    logic cont_q;
    logic [15:0] attr_q;
    logic [63:0] pat_q;
    logic [2:0] w_q;
    logic [5:0] line_q;
    logic [7:0] pidx_q;

    logic acc;
    logic wr_fire;
    logic start;
    logic [7:0] fx;
    logic [7:0] fy;
    logic [5:0] nb;
    logic [5:0] skip;
    logic [2:0] nw;
    logic [5:0] rows;
    logic [6:0] nrem;
    logic [11:0] dx;
    logic [11:0] dy_off;
    logic [11:0] dy;
    logic printing;
    logic done_ack;
    logic step;
    logic [63:0] a_wd_hi;
    logic [63:0] a_wm_hi;
    logic [63:0] a_wd_lo;
    logic [63:0] a_wm_lo;
    logic a_second;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign chr_ready = chr_ready_q;
    assign mem_req = mem_req_q;
    assign mem_we = mem_we_q;
    assign mem_xw = mem_xw_q;
    assign mem_y = mem_y_q;
    assign mem_wdata = mem_wdata_q;
    assign mem_wmask = mem_wmask_q;
    assign busy = busy_q;

    // APB: one wait state; write commits at the completing edge
    assign acc = psel & penable;
    assign wr_fire = acc & pready_q & pwrite & mapped(paddr);
    assign start = wr_fire && (paddr == ADDR_CMD) && !busy_q
        && (pwdata[START_BIT] || pwdata[CURRENT_BIT]);

    // Font and cell geometry
    assign fx = fsel_q ? fbase_q[23:16] : fbase_q[7:0];
    assign fy = fsel_q ? fbase_q[31:24] : fbase_q[15:8];
    assign nb = scaled(attr_q[H_LSB +: 4], cs_q);
    assign skip = scaled(attr_q[S_LSB +: 4], cs_q);
    assign nw = 3'(({1'b0, nb} + 7'd15) >> 4);
    assign rows = (cell_h_q > skip) ? cell_h_q - skip : 6'h00;
    assign nrem = {1'b0, nb} - {w_q, 4'h0};
    assign printing = (attr_q[H_LSB +: 4] != 4'h0);
    assign dx = pen_x_q + {5'h00, w_q, 4'h0};
    assign dy_off = {6'h00, skip} + {6'h00, line_q};
    // Direction bit 0 clear draws downward from the pen
    assign dy = attr_q[D_LSB] ? pen_y_q - dy_off : pen_y_q + dy_off;
    assign done_ack = mem_req_q & mem_ack;
    assign step = done_ack && ((state_q == ST_WR1 && !a_second) || state_q == ST_WR2);

    czd_align u_align (
        .pat(pat_q),
        .sp(sp_q),
        .fp(fp_q),
        .nrem(nrem),
        .invert(si_q),
        .op(op_q),
        .colour(colour_q),
        .active(active_q),
        .offset(dx[3:0]),
        .wd_hi(a_wd_hi),
        .wm_hi(a_wm_hi),
        .wd_lo(a_wd_lo),
        .wm_lo(a_wm_lo),
        .second(a_second)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= RST_WORD;
        end else if (ce) begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~mapped(paddr);
            prdata_q <= RST_WORD;
            if (acc && !pready_q && !pwrite) begin
                unique case (paddr)
                    ADDR_FONT_CFG: prdata_q <= {28'h000_0000, rc_q, cs_q, fp_q};
                    ADDR_FONT_BASE: prdata_q <= fbase_q;
                    ADDR_RETURN: prdata_q <= {20'h0_0000, ret_q};
                    ADDR_STR_CFG: prdata_q <= {10'h000, cell_h_q, colour_q, active_q,
                        3'h0, op_q, si_q, sp_q};
                    ADDR_BEGIN: prdata_q <= {4'h0, begin_y_q, 4'h0, begin_x_q};
                    ADDR_CMD: prdata_q <= {31'h0000_0000, busy_q};
                    ADDR_PEN: prdata_q <= {4'h0, pen_y_q, 4'h0, pen_x_q};
                    default: prdata_q <= RST_WORD;
                endcase
            end
        end
    end

    // Font base and return location
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fp_q <= 2'h0;
            cs_q <= 1'b0;
            rc_q <= 1'b0;
            fbase_q <= RST_WORD;
            ret_q <= 12'h000;
        end else if (ce && wr_fire) begin
            if (paddr == ADDR_FONT_CFG) begin
                fp_q <= pwdata[FP_LSB +: 2];
                cs_q <= pwdata[CS_BIT];
                rc_q <= pwdata[RC_BIT];
            end
            if (paddr == ADDR_FONT_BASE) begin
                fbase_q <= pwdata;
            end
            // Only the selected component survives; the other is dropped
            if (paddr == ADDR_RETURN) begin
                ret_q <= rc_q ? pwdata[Y_LSB +: 12] : pwdata[X_LSB +: 12];
            end
        end
    end

    // String options and begin operand
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= 1'b0;
            si_q <= 1'b0;
            op_q <= RST_OP;
            active_q <= RST_ACTIVE;
            colour_q <= RST_COLOUR;
            cell_h_q <= RST_CELL_HEIGHT;
            begin_x_q <= 12'h000;
            begin_y_q <= 12'h000;
        end else if (ce && wr_fire) begin
            if (paddr == ADDR_STR_CFG) begin
                sp_q <= pwdata[SP_BIT];
                si_q <= pwdata[SI_BIT];
                op_q <= pwdata[OP_LSB +: 3];
                active_q <= pwdata[ACT_LSB +: 4];
                colour_q <= pwdata[COL_LSB +: 4];
                cell_h_q <= pwdata[HGT_LSB +: 6];
            end
            if (paddr == ADDR_BEGIN) begin
                begin_x_q <= pwdata[X_LSB +: 12];
                begin_y_q <= pwdata[Y_LSB +: 12];
            end
        end
    end

    // Pen position moves only at string start and character boundaries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pen_x_q <= 12'h000;
            pen_y_q <= 12'h000;
        end else if (ce) begin
            if (start && pwdata[START_BIT]) begin
                pen_x_q <= begin_x_q;
                pen_y_q <= begin_y_q;
            end else if (state_q == ST_DEC && !printing) begin
                if (attr_q[S_LSB]) begin
                    pen_x_q <= ret_q;
                end
                if (attr_q[S_LSB + 1]) begin
                    pen_y_q <= ret_q;
                end
            end else if (state_q == ST_ADV) begin
                unique case (attr_q[D_LSB +: 2])
                    2'b10: pen_y_q <= pen_y_q + {6'h00, attr_q[ICO_LSB +: 6]};
                    2'b11: pen_y_q <= pen_y_q - {6'h00, attr_q[ICO_LSB +: 6]};
                    default: pen_x_q <= pen_x_q + {6'h00, attr_q[ICO_LSB +: 6]};
                endcase
            end
        end
    end

    // Sequencer and display memory port; each access holds req until ack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            chr_ready_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_xw_q <= 8'h00;
            mem_y_q <= 12'h000;
            mem_wdata_q <= 64'h0000_0000_0000_0000;
            mem_wmask_q <= 64'h0000_0000_0000_0000;
            code_q <= 12'h000;
            fsel_q <= 1'b0;
            cont_q <= 1'b0;
            attr_q <= 16'h0000;
            pat_q <= 64'h0000_0000_0000_0000;
            w_q <= 3'h0;
            line_q <= 6'h00;
            pidx_q <= 8'h00;
        end else if (ce) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_WCHR;
                        busy_q <= 1'b1;
                        chr_ready_q <= 1'b1;
                    end
                end
                ST_WCHR: begin
                    if (chr_valid && chr_ready_q) begin
                        code_q <= chr_entry[11:0];
                        fsel_q <= chr_entry[FSEL_BIT];
                        cont_q <= chr_entry[CONT_BIT];
                        chr_ready_q <= 1'b0;
                        state_q <= ST_ATTR;
                    end
                end
                ST_ATTR: begin
                    if (!mem_req_q) begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        // Word address of base times 16 is the 8-bit field itself
                        mem_xw_q <= fx;
                        mem_y_q <= ({4'h0, fy} << FONT_SHIFT) + code_q;
                    end else if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        attr_q <= mem_rdata[16*fp_q +: 16];
                        state_q <= ST_DEC;
                    end
                end
                ST_DEC: begin
                    w_q <= 3'h0;
                    line_q <= 6'h00;
                    pidx_q <= fx + 8'h01;
                    if (!printing) begin
                        if (attr_q[ES_BIT] || !cont_q) begin
                            state_q <= ST_IDLE;
                            busy_q <= 1'b0;
                        end else begin
                            state_q <= ST_WCHR;
                            chr_ready_q <= 1'b1;
                        end
                    end else if (rows == 6'h00) begin
                        state_q <= ST_ADV;
                    end else begin
                        state_q <= ST_PAT;
                    end
                end
                ST_PAT: begin
                    if (!mem_req_q) begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        mem_xw_q <= pidx_q;
                        mem_y_q <= ({4'h0, fy} << FONT_SHIFT) + code_q;
                    end else if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        pat_q <= mem_rdata;
                        state_q <= ST_WR1;
                    end
                end
                ST_WR1: begin
                    if (!mem_req_q) begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b1;
                        mem_xw_q <= dx[11:4];
                        mem_y_q <= dy;
                        mem_wdata_q <= a_wd_hi;
                        mem_wmask_q <= a_wm_hi;
                    end else if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        if (a_second) begin
                            state_q <= ST_WR2;
                        end
                    end
                end
                ST_WR2: begin
                    if (!mem_req_q) begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b1;
                        mem_xw_q <= dx[11:4] + 8'h01;
                        mem_y_q <= dy;
                        mem_wdata_q <= a_wd_lo;
                        mem_wmask_q <= a_wm_lo;
                    end else if (mem_ack) begin
                        mem_req_q <= 1'b0;
                    end
                end
                ST_ADV: begin
                    if (cont_q) begin
                        state_q <= ST_WCHR;
                        chr_ready_q <= 1'b1;
                    end else begin
                        state_q <= ST_IDLE;
                        busy_q <= 1'b0;
                    end
                end
            endcase
            // Next pattern word, or next scan line, after the last write of a word
            if (step) begin
                pidx_q <= pidx_q + 8'h01;
                if (w_q + 3'h1 == nw) begin
                    w_q <= 3'h0;
                    line_q <= line_q + 6'h01;
                    state_q <= (line_q + 6'h01 == rows) ? ST_ADV : ST_PAT;
                end else begin
                    w_q <= w_q + 3'h1;
                    state_q <= ST_PAT;
                end
            end
        end
    end
endmodule

// ==== design/czd_pkg.sv ====
// Register map, field positions, reset values and state codes of the string drawer
package czd_pkg;
    localparam logic [7:0] ADDR_FONT_CFG = 8'h00;
    localparam logic [7:0] ADDR_FONT_BASE = 8'h04;
    localparam logic [7:0] ADDR_RETURN = 8'h08;
    localparam logic [7:0] ADDR_STR_CFG = 8'h0C;
    localparam logic [7:0] ADDR_BEGIN = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    localparam logic [7:0] ADDR_PEN = 8'h18;
    // Font configuration fields
    localparam int FP_LSB = 0;
    localparam int CS_BIT = 2;
    localparam int RC_BIT = 3;
    // String configuration fields
    localparam int SP_BIT = 0;
    localparam int SI_BIT = 1;
    localparam int OP_LSB = 2;
    localparam int ACT_LSB = 8;
    localparam int COL_LSB = 12;
    localparam int HGT_LSB = 16;
    // Position words and command bits
    localparam int X_LSB = 0;
    localparam int Y_LSB = 16;
    localparam int START_BIT = 0;
    localparam int CURRENT_BIT = 1;
    // Attribute word
    localparam int H_LSB = 12;
    localparam int S_LSB = 8;
    localparam int ES_BIT = 11;
    localparam int D_LSB = 6;
    localparam int ICO_LSB = 0;
    // List entry
    localparam int CONT_BIT = 13;
    localparam int FSEL_BIT = 12;
    // Font base coordinates are 8-bit values times 16
    localparam int FONT_SHIFT = 4;
    localparam logic [2:0] OP_GRAPHICAL_SET = 3'h5;
    localparam logic [5:0] RST_CELL_HEIGHT = 6'h10;
    localparam logic [3:0] RST_ACTIVE = 4'hF;
    localparam logic [3:0] RST_COLOUR = 4'hF;
    localparam logic [2:0] RST_OP = OP_GRAPHICAL_SET;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WCHR = 3'b001,
        ST_ATTR = 3'b010,
        ST_DEC = 3'b011,
        ST_PAT = 3'b100,
        ST_WR1 = 3'b101,
        ST_WR2 = 3'b110,
        ST_ADV = 3'b111
    } czd_state_type;
endpackage

// ==== design/czd_align.sv ====
// Pattern alignment, inversion and per-plane write masks for one destination word pair
`timescale 1ns/100ps
module czd_align (
    input wire logic [63:0] pat,
    input wire logic sp,
    input wire logic [1:0] fp,
    input wire logic [6:0] nrem,
    input wire logic invert,
    input wire logic [2:0] op,
    input wire logic [3:0] colour,
    input wire logic [3:0] active,
    input wire logic [3:0] offset,
    output logic [63:0] wd_hi,
    output logic [63:0] wm_hi,
    output logic [63:0] wd_lo,
    output logic [63:0] wm_lo,
    output logic second
);
    import czd_pkg::*;

    logic [15:0] valid;

    // Leftmost pixel is bit 15; unused right bits of the last word drop out
    assign valid = (nrem >= 7'd16) ? 16'hFFFF : ~(16'hFFFF >> nrem[3:0]);

    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_plane
            logic [15:0] src;
            logic [15:0] bits;
            logic [15:0] msk;
            logic [15:0] dat;
            logic [31:0] msh;
            logic [31:0] dsh;
            // Source plane is read whatever its activity bit says
            assign src = sp ? pat[16*fp +: 16] : pat[16*p +: 16];
            assign bits = (invert ? ~src : src) & valid;
            // Set paints colour under ones only; other codes replace the cell
            assign msk = !active[p] ? 16'h0000 :
                (op == OP_GRAPHICAL_SET) ? bits : valid;
            assign dat = (op == OP_GRAPHICAL_SET) ? {16{colour[p]}} : bits & {16{colour[p]}};
            assign msh = {msk, 16'h0000} >> offset;
            assign dsh = {dat, 16'h0000} >> offset;
            assign wm_hi[16*p +: 16] = msh[31:16];
            assign wm_lo[16*p +: 16] = msh[15:0];
            assign wd_hi[16*p +: 16] = dsh[31:16];
            assign wd_lo[16*p +: 16] = dsh[15:0];
        end
    endgenerate

    assign second = |wm_lo;
endmodule

// ==== sim/czd_checker_properties.sv ====
// Port-level assertions for the string drawer
`timescale 1ns/100ps
module czd_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chr_valid,
    input wire logic chr_ready,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [7:0] mem_xw,
    input wire logic [11:0] mem_y,
    input wire logic [63:0] mem_wmask,
    input wire logic mem_ack,
    input wire logic busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence mem_done;
        mem_req && mem_ack;
    endsequence
    sequence chr_taken;
        chr_valid && chr_ready;
    endsequence
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    slverr_only_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero");
    req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_xw)
        && $stable(mem_y) && $stable(mem_wmask) && $stable(mem_we))
        else $error("memory request moved");
    req_drop_a: assert property (mem_done |=> !mem_req)
        else $error("request not dropped");
    chr_fetch_a: assert property (chr_taken |=> !chr_ready ##1 (mem_req && !mem_we))
        else $error("no attribute read");
    idle_quiet_a: assert property (!busy |-> !mem_req && !chr_ready)
        else $error("activity while idle");
endmodule

// ==== sim/czd_mem_model.sv ====
// Display memory model: font attribute and pattern store, write recorder
`timescale 1ns/100ps
module czd_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic clr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [7:0] mem_xw,
    input wire logic [11:0] mem_y,
    input wire logic [63:0] mem_wmask,
    output logic [63:0] mem_rdata,
    output logic mem_ack,
    output int wr_count,
    output logic [63:0] mask_or,
    output logic [11:0] wr_y0,
    output logic [11:0] attr_y
);
    logic [3:0] wait_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_q <= 4'h0;
            mem_rdata <= 64'h0000_0000_0000_0000;
            wr_count <= 0;
            mask_or <= 64'h0000_0000_0000_0000;
            wr_y0 <= 12'h000;
            attr_y <= 12'h000;
        end else begin
            mem_ack <= 1'b0;
            // Idle data keeps toggling so stale reads show up
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                if (wait_q < (slow ? 4'h3 : 4'h0)) begin
                    wait_q <= wait_q + 4'h1;
                end else begin
                    wait_q <= 4'h0;
                    mem_ack <= 1'b1;
                    if (mem_we) begin
                        wr_count <= wr_count + 1;
                        mask_or <= mask_or | mem_wmask;
                        if (wr_count == 0) wr_y0 <= mem_y;
                    end else if (mem_xw == 8'h01) begin
                        attr_y <= mem_y;
                        // Codes ending in 1 print; others end the string with X return
                        mem_rdata <= {48'h3C3C_A5A5_5A5A, (mem_y[3:0] == 4'h1) ? 16'h610C : 16'h0900};
                    end else begin
                        // Font in plane 0 only; other planes hold noise
                        mem_rdata <= 64'h1234_5678_9ABC_FFFF;
                    end
                end
            end
            if (clr) begin
                wr_count <= 0;
                mask_or <= 64'h0000_0000_0000_0000;
            end
        end
    end
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the string drawer
`timescale 1ns/100ps
module testbench;
    import czd_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, chr_valid = 0;
    logic slow = 0, clr = 0, busy, pready, pslverr, chr_ready, mem_req, mem_we, mem_ack;
    logic [7:0] paddr = 8'h00, mem_xw;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [13:0] chr_entry = 14'h0000;
    logic [11:0] mem_y, wr_y0, attr_y;
    logic [63:0] mem_wdata, mem_wmask, mem_rdata, mask_or, data_or;
    int wr_count, errors = 0, checked = 0, cycles = 0;
    czd_string_drawer u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chr_valid(chr_valid), .chr_entry(chr_entry),
        .chr_ready(chr_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_xw(mem_xw),
        .mem_y(mem_y), .mem_wdata(mem_wdata), .mem_wmask(mem_wmask), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .busy(busy));
    czd_mem_model u_mem (.pclk(pclk), .presetn(presetn), .slow(slow), .clr(clr),
        .mem_req(mem_req), .mem_we(mem_we), .mem_xw(mem_xw), .mem_y(mem_y),
        .mem_wmask(mem_wmask), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .wr_count(wr_count), .mask_or(mask_or), .wr_y0(wr_y0), .attr_y(attr_y));
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic stop_test();
        if (errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            stop_test();
        end
    end
    // Colour actually landed under the write mask
    always @(posedge pclk) begin
        if (clr) data_or <= 64'h0000_0000_0000_0000;
        else if (mem_req && mem_ack && mem_we) data_or <= data_or | (mem_wdata & mem_wmask);
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the global cycle ceiling ends a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, exp);
    endtask
    task automatic push(input logic [13:0] e);
        @(posedge pclk);
        chr_valid <= 1'b1;
        chr_entry <= e;
        do begin
            @(posedge pclk);
        end while (chr_ready !== 1'b1);
        chr_valid <= 1'b0;
        chr_entry <= ~e;
    endtask
    task automatic run(input logic [31:0] cmd, input logic [13:0] e0, input logic [13:0] e1);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        wr(ADDR_CMD, cmd);
        push(e0);
        if (e0[CONT_BIT]) push(e1);
        while (busy !== 1'b0) @(posedge pclk);
    endtask
    task automatic t_reset_map();
        logic [31:0] q;
        logic e;
        rd(ADDR_STR_CFG, 32'h0010_FF14);
        rd(ADDR_PEN, 32'h0000_0000);
        apb(1'b0, 8'h1C, 32'h0000_0000, q, e);
        chk({63'h0, e}, 64'h1);
    endtask
    task automatic t_first_char();
        wr(ADDR_FONT_CFG, 32'h0000_0000);
        wr(ADDR_FONT_BASE, 32'h0301_0201);
        wr(ADDR_STR_CFG, 32'h0010_FF15);
        wr(ADDR_BEGIN, 32'h0300_0200);
        run(32'h0000_0001, 14'h0041, 14'h0000);
        chk(attr_y, 12'h061);
        chk(wr_count, 14);
        chk(wr_y0, 12'h302);
        chk(mask_or, {4{16'hFFF0}});
        rd(ADDR_PEN, 32'h0300_020C);
    endtask
    task automatic t_straddle();
        // Font plane inactive, font still read
        wr(ADDR_STR_CFG, 32'h0010_9A15);
        run(32'h0000_0002, 14'h1041, 14'h0000);
        chk(attr_y, 12'h071);
        chk(wr_count, 28);
        chk(mask_or, 64'hFF0F_0000_FF0F_0000);
        chk(data_or, 64'hFF0F_0000_0000_0000);
        rd(ADDR_PEN, 32'h0300_0218);
    endtask
    task automatic t_return();
        slow <= 1'b1;
        wr(ADDR_FONT_CFG, 32'h0000_0004);
        wr(ADDR_RETURN, 32'h0777_0100);
        rd(ADDR_RETURN, 32'h0000_0100);
        wr(ADDR_STR_CFG, 32'h0010_FF15);
        run(32'h0000_0001, 14'h2041, 14'h200D);
        chk(wr_count, 24);
        chk(wr_y0, 12'h304);
        rd(ADDR_PEN, 32'h0300_0100);
        rd(ADDR_CMD, 32'h0000_0000);
    endtask
    task automatic t_invert();
        slow <= 1'b0;
        wr(ADDR_STR_CFG, 32'h0010_FF17);
        run(32'h0000_0002, 14'h0041, 14'h0000);
        chk(mask_or, 64'h0000_0000_0000_0000);
        rd(ADDR_PEN, 32'h0300_010C);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_map();
        t_first_char();
        t_straddle();
        t_return();
        t_invert();
        stop_test();
    end
endmodule
bind czd_string_drawer czd_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chr_valid(chr_valid), .chr_ready(chr_ready), .mem_req(mem_req), .mem_we(mem_we),
    .mem_xw(mem_xw), .mem_y(mem_y), .mem_wmask(mem_wmask), .mem_ack(mem_ack), .busy(busy));
